// >>> hdl/msr_map.svh
// register offsets, field positions, reset values and bus constants
`ifndef MSR_MAP_SVH
`define MSR_MAP_SVH

// ======================================================
// serial port
`define MSR_DEV_ADDR 7'h52
`define MSR_BYTE_BITS 4'h8

// ======================================================
// register offsets
`define MSR_OFS_SPD_LO 8'h00
`define MSR_OFS_SPD_HI 8'h01
`define MSR_OFS_KEY 8'h02
`define MSR_OFS_NVC 8'h03
`define MSR_OFS_STAT 8'h10
`define MSR_OFS_RO_LAST 8'h1e
`define MSR_OFS_CFG_FIRST 8'h20
`define MSR_OFS_CFG_LAST 8'h2b

// ======================================================
// field positions
`define MSR_HI_TAKEOVER 7
`define MSR_HI_MSB 0
`define MSR_NVC_INHIBIT 7
`define MSR_NVC_CFG_WE 6
`define MSR_NVC_RELOAD 5
`define MSR_NVC_PROGRAM 4
`define MSR_ST_THERMAL 7
`define MSR_ST_LOW_POWER 6
`define MSR_ST_CURRENT 5
`define MSR_ST_ROTOR 4

// ======================================================
// values and masks
`define MSR_UNLOCK_KEY 8'hb6
`define MSR_NVC_MASK 8'hf0
`define MSR_RST_BYTE 8'h00

`endif

// >>> hdl/msr_pkg.sv
// types shared by the motor control and status register block
package msr_pkg;

  // ======================================================
  // serial engine states
  typedef enum logic [4:0] {
    MSR_S_IDLE = 5'h01,
    MSR_S_RX = 5'h02,
    MSR_S_ACK = 5'h04,
    MSR_S_TX = 5'h08,
    MSR_S_TXACK = 5'h10
  } msr_state_e_t;

  typedef enum logic [2:0] {
    MSR_PH_ADDR = 3'h1,
    MSR_PH_PTR = 3'h2,
    MSR_PH_DATA = 3'h4
  } msr_phase_e_t;

  // ======================================================
  // carriers
  typedef struct packed {
    logic thermal;
    logic low_power;
    logic current;
    logic rotor;
  } msr_status_t;

  typedef struct packed {
    logic stb;
    logic [7:0] addr;
    logic [7:0] data;
  } msr_wr_t;

  // ======================================================
  // module state
  typedef struct packed {
    logic flag;
  } msr_sticky_st_t;

  typedef struct packed {
    logic [7:0] key;
    logic prog;
  } msr_key_st_t;

  typedef struct packed {
    msr_state_e_t st;
    msr_phase_e_t phase;
    logic scl_p;
    logic sda_p;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic [7:0] ptr;
    logic sda_oe;
    logic [7:0] spd_lo;
    logic spd_msb;
    logic takeover;
    logic [8:0] spd_val;
    logic [7:0] nvc;
    logic reload;
    msr_wr_t cfg;
    logic [8:0] spd_out;
    logic lp_allow;
  } msr_main_st_t;

endpackage

// >>> hdl/msr_sticky.sv
// sticky event flag, set wins over clear
`timescale 1ns/10ps
`default_nettype none
module msr_sticky
  import msr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic set,
  input wire logic clr,
  output logic q
);

  msr_sticky_st_t st_q;
  msr_sticky_st_t st_d;

  // ======================================================
  // next state
  always_comb begin
    st_d = st_q;
    if (clr) begin
      st_d.flag = 1'b0;
    end
    if (set) begin
      st_d.flag = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign q = st_q.flag;

  // ======================================================
  // checks
  a_set_holds: assert property (@(posedge ref_clk) disable iff (rst)
    ce && set |=> q ##1 (q || $past(clr) || !$past(ce)))
    else $error("sticky flag lost after set");
  a_clear_read: assert property (@(posedge ref_clk) disable iff (rst)
    ce && clr && !set |=> !q)
    else $error("sticky flag not cleared by read");
  c_flag_set: cover property (@(posedge ref_clk) disable iff (rst) ce && set && !q);

endmodule
`default_nettype wire

// >>> hdl/msr_key_seq.sv
// unlock key register and non-volatile programming sequence
`include "msr_map.svh"
`timescale 1ns/10ps
`default_nettype none
module msr_key_seq
  import msr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire msr_wr_t wr,
  output logic [7:0] key,
  output logic prog
);

  msr_key_st_t st_q;
  msr_key_st_t st_d;

  // ======================================================
  // next state
  always_comb begin
    st_d = st_q;
    st_d.prog = 1'b0;
    if (wr.stb) begin
      if (wr.addr == `MSR_OFS_KEY) begin
        st_d.key = wr.data;
      end else if (wr.addr == `MSR_OFS_NVC && wr.data[`MSR_NVC_PROGRAM] &&
                   st_q.key == `MSR_UNLOCK_KEY) begin
        st_d.prog = 1'b1;
        st_d.key = `MSR_RST_BYTE;
      end else begin
        st_d.key = `MSR_RST_BYTE;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign key = st_q.key;
  assign prog = st_q.prog;

  // ======================================================
  // checks
  a_prog_needs_key: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(prog) |-> $past(st_q.key) == `MSR_UNLOCK_KEY && $past(wr.addr) == `MSR_OFS_NVC)
    else $error("program pulse without unlock key");
  a_key_cleared: assert property (@(posedge ref_clk) disable iff (rst)
    ce && wr.stb && wr.addr != `MSR_OFS_KEY |=> key == `MSR_RST_BYTE)
    else $error("unlock key survived another write");
  c_prog: cover property (@(posedge ref_clk) disable iff (rst) prog);

endmodule
`default_nettype wire

// >>> hdl/msr_regs.sv
// motor control and status registers behind a two-wire serial slave
// ======================================================
`include "msr_map.svh"
`timescale 1ns/10ps
`default_nettype none
module msr_regs
  import msr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire msr_status_t status_in,
  input wire logic [8:0] pin_speed,
  input wire logic low_power_request,
  output logic [8:0] speed_command_value,
  output logic host_speed_takeover,
  output logic low_power_inhibit,
  output logic low_power_allow,
  output logic config_write_enable,
  output msr_wr_t cfg_wr,
  output logic nonvolatile_reload,
  output logic nonvolatile_program
);

  msr_main_st_t st_q;
  msr_main_st_t st_d;
  msr_wr_t reg_wr;
  logic rd_ev;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic [7:0] rd_byte;
  logic [7:0] key;
  logic current_flag;

  // ======================================================
  // read mux
  always_comb begin
    case (st_q.ptr)
      `MSR_OFS_SPD_LO: rd_byte = st_q.spd_lo;
      `MSR_OFS_SPD_HI: rd_byte = {st_q.takeover, 6'h00, st_q.spd_msb};
      `MSR_OFS_KEY: rd_byte = key;
      `MSR_OFS_NVC: rd_byte = st_q.nvc & `MSR_NVC_MASK;
      `MSR_OFS_STAT: rd_byte = {status_in.thermal, status_in.low_power,
                                current_flag, status_in.rotor, 4'h0};
      default: rd_byte = `MSR_RST_BYTE;
    endcase
  end

  assign scl_rise = scl_i && !st_q.scl_p;
  assign scl_fall = !scl_i && st_q.scl_p;
  assign start_c = scl_i && st_q.scl_p && st_q.sda_p && !sda_i;
  assign stop_c = scl_i && st_q.scl_p && !st_q.sda_p && sda_i;

  // ======================================================
  // serial engine and register writes
  always_comb begin
    st_d = st_q;
    st_d.scl_p = scl_i;
    st_d.sda_p = sda_i;
    st_d.reload = 1'b0;
    st_d.cfg.stb = 1'b0;
    reg_wr = '0;
    rd_ev = 1'b0;
    if (start_c) begin
      st_d.st = MSR_S_RX;
      st_d.phase = MSR_PH_ADDR;
      st_d.cnt = 4'h0;
      st_d.rw = 1'b0;
      st_d.sda_oe = 1'b0;
    end else if (stop_c) begin
      st_d.st = MSR_S_IDLE;
      st_d.sda_oe = 1'b0;
    end else begin
      case (st_q.st)
        MSR_S_IDLE: begin
          st_d.sda_oe = 1'b0;
        end
        MSR_S_RX: begin
          if (scl_rise && st_q.cnt != `MSR_BYTE_BITS) begin
            st_d.sh = {st_q.sh[6:0], sda_i};
            st_d.cnt = st_q.cnt + 4'h1;
          end else if (scl_fall && st_q.cnt == `MSR_BYTE_BITS) begin
            st_d.cnt = 4'h0;
            st_d.st = MSR_S_ACK;
            st_d.sda_oe = 1'b1;
            case (st_q.phase)
              MSR_PH_ADDR: begin
                if (st_q.sh[7:1] == `MSR_DEV_ADDR) begin
                  st_d.rw = st_q.sh[0];
                  st_d.phase = MSR_PH_PTR;
                end else begin
                  st_d.st = MSR_S_IDLE;
                  st_d.sda_oe = 1'b0;
                end
              end
              MSR_PH_PTR: begin
                st_d.ptr = st_q.sh;
                st_d.phase = MSR_PH_DATA;
              end
              default: begin
                reg_wr.stb = 1'b1;
                reg_wr.addr = st_q.ptr;
                reg_wr.data = st_q.sh;
                st_d.ptr = st_q.ptr + 8'h01;
              end
            endcase
          end
        end
        MSR_S_ACK: begin
          if (scl_fall) begin
            if (st_q.rw) begin
              rd_ev = 1'b1;
              st_d.sh = rd_byte;
              st_d.sda_oe = !rd_byte[7];
              st_d.ptr = st_q.ptr + 8'h01;
              st_d.cnt = 4'h0;
              st_d.st = MSR_S_TX;
            end else begin
              st_d.sda_oe = 1'b0;
              st_d.st = MSR_S_RX;
            end
          end
        end
        MSR_S_TX: begin
          if (scl_rise) begin
            st_d.cnt = st_q.cnt + 4'h1;
          end else if (scl_fall) begin
            if (st_q.cnt == `MSR_BYTE_BITS) begin
              st_d.sda_oe = 1'b0;
              st_d.cnt = 4'h0;
              st_d.st = MSR_S_TXACK;
            end else begin
              st_d.sh = {st_q.sh[6:0], 1'b0};
              st_d.sda_oe = !st_q.sh[6];
            end
          end
        end
        MSR_S_TXACK: begin
          if (scl_rise) begin
            st_d.st = sda_i ? MSR_S_IDLE : MSR_S_ACK;
          end
        end
        default: begin
          st_d.st = MSR_S_IDLE;
          st_d.sda_oe = 1'b0;
        end
      endcase
    end

    // register effects; 0x10..0x1e and unmapped offsets take no write
    if (reg_wr.stb) begin
      case (reg_wr.addr)
        `MSR_OFS_SPD_LO: begin
          st_d.spd_lo = reg_wr.data;
          st_d.spd_val = {st_q.spd_msb, reg_wr.data};
        end
        `MSR_OFS_SPD_HI: begin
          st_d.spd_msb = reg_wr.data[`MSR_HI_MSB];
          st_d.takeover = reg_wr.data[`MSR_HI_TAKEOVER];
        end
        `MSR_OFS_NVC: begin
          st_d.nvc = reg_wr.data & `MSR_NVC_MASK;
          st_d.reload = reg_wr.data[`MSR_NVC_RELOAD];
        end
        default: begin
          if (reg_wr.addr >= `MSR_OFS_CFG_FIRST && reg_wr.addr <= `MSR_OFS_CFG_LAST &&
              st_q.nvc[`MSR_NVC_CFG_WE]) begin
            st_d.cfg = reg_wr;
          end
        end
      endcase
    end
    st_d.spd_out = st_q.takeover ? st_q.spd_val : pin_speed;
    st_d.lp_allow = low_power_request && !st_q.nvc[`MSR_NVC_INHIBIT];
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
      st_q.st <= MSR_S_IDLE;
      st_q.phase <= MSR_PH_ADDR;
      st_q.scl_p <= 1'b1;
      st_q.sda_p <= 1'b1;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // ======================================================
  // sub-blocks
  msr_sticky u_current (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .set(status_in.current),
    .clr(rd_ev && st_q.ptr == `MSR_OFS_STAT),
    .q(current_flag)
  );

  msr_key_seq u_key (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .wr(reg_wr),
    .key(key),
    .prog(nonvolatile_program)
  );

  // ======================================================
  // outputs
  assign sda_o = 1'b0;
  assign sda_oe = st_q.sda_oe;
  assign speed_command_value = st_q.spd_out;
  assign host_speed_takeover = st_q.takeover;
  assign low_power_inhibit = st_q.nvc[`MSR_NVC_INHIBIT];
  assign low_power_allow = st_q.lp_allow;
  assign config_write_enable = st_q.nvc[`MSR_NVC_CFG_WE];
  assign cfg_wr = st_q.cfg;
  assign nonvolatile_reload = st_q.reload;

  // ======================================================
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_low_snapshot: assert property (
    ce && reg_wr.stb && reg_wr.addr == `MSR_OFS_SPD_LO
    |=> st_q.spd_val == {$past(st_q.spd_msb), $past(reg_wr.data)})
    else $error("speed low write did not snapshot top bit");
  a_msb_store: assert property (
    ce && reg_wr.stb && reg_wr.addr == `MSR_OFS_SPD_HI
    |=> st_q.spd_msb == $past(reg_wr.data[0]) && $stable(st_q.spd_val))
    else $error("top speed bit not stored or leaked early");
  a_speed_select: assert property (
    ce |=> speed_command_value == ($past(st_q.takeover) ? $past(st_q.spd_val)
                                   : $past(pin_speed)))
    else $error("speed source select wrong");
  a_lp_inhibit: assert property (
    ce && st_q.nvc[7] |=> !low_power_allow)
    else $error("low power allowed while inhibited");
  a_cfg_gate: assert property (
    $rose(cfg_wr.stb) |-> $past(st_q.nvc[6]))
    else $error("config write without enable");
  a_reload_pulse: assert property (
    ce && reg_wr.stb && reg_wr.addr == `MSR_OFS_NVC && reg_wr.data[5]
    |=> nonvolatile_reload ##1 (!nonvolatile_reload || !$past(ce)))
    else $error("reload pulse wrong");
  a_hi_unused_zero: assert property (
    st_q.ptr == `MSR_OFS_SPD_HI |-> rd_byte[6:1] == 6'h00)
    else $error("unused speed bits not zero");
  a_status_live: assert property (
    st_q.ptr == `MSR_OFS_STAT |-> rd_byte[7] == status_in.thermal &&
    rd_byte[6] == status_in.low_power && rd_byte[4] == status_in.rotor)
    else $error("status bits do not follow inputs");
  a_addr_nack: assert property (
    ce && st_q.st == MSR_S_RX && st_q.phase == MSR_PH_ADDR && scl_fall && !start_c &&
    !stop_c && st_q.cnt == 4'h8 && st_q.sh[7:1] != 7'h52 |=> !sda_oe && st_q.st == MSR_S_IDLE)
    else $error("foreign address acknowledged");
  a_ro_ignore: assert property (
    ce && reg_wr.stb && reg_wr.addr >= 8'h10 && reg_wr.addr <= 8'h1e
    |=> $stable(st_q.spd_val) && $stable(st_q.nvc) && $stable(st_q.takeover))
    else $error("read-only write changed state");
  a_ce_freeze: assert property (
    !ce |=> $stable(st_q))
    else $error("state moved while clock enable low");

  c_low_write: cover property (reg_wr.stb && reg_wr.addr == `MSR_OFS_SPD_LO);
  c_status_read: cover property (rd_ev && st_q.ptr == `MSR_OFS_STAT);
  c_cfg_write: cover property (cfg_wr.stb);

endmodule
`default_nettype wire

// >>> sim/msr_host_model.sv
// two-wire bus master model standing in for the host controller
`timescale 1ns/10ps
`default_nettype none
module msr_host_model (
  input wire logic ref_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  int half = 6;
  logic [6:0] dev_addr = 7'h52;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // ======================================================
  // bus conditions and bits
  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic start_cond();
    sda_low <= 1'b0;
    tk(half);
    scl <= 1'b1;
    tk(half);
    sda_low <= 1'b1;
    tk(half);
    scl <= 1'b0;
    tk(2);
  endtask
  task automatic stop_cond();
    sda_low <= 1'b1;
    tk(half);
    scl <= 1'b1;
    tk(half);
    sda_low <= 1'b0;
    tk(half);
  endtask
  task automatic put_bit(input logic b, output logic s);
    sda_low <= ~b;
    tk(half);
    scl <= 1'b1;
    tk(2);
    s = sda_line;
    tk(half - 2);
    scl <= 1'b0;
    tk(2);
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(d[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, s);
      d[i] = s;
    end
    put_bit(last, s);
  endtask
  // ======================================================
  // register transfers
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start_cond();
    wr_byte({dev_addr, 1'b0}, a0);
    wr_byte(a, a1);
    wr_byte(d, a2);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start_cond();
    wr_byte({dev_addr, 1'b0}, a0);
    wr_byte(a, a1);
    start_cond();
    wr_byte({dev_addr, 1'b1}, a2);
    rd_byte(1'b1, d);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask
endmodule
`default_nettype wire

// >>> sim/test_motor_driver_control_status_regs.sv
// self-checking bench for the motor control and status register block
`timescale 1ns/10ps
`default_nettype none
module test_motor_driver_control_status_regs
  import msr_pkg::*;
;
  logic ref_clk;
  logic rst;
  logic ce;
  logic sda_o;
  logic sda_oe;
  logic scl;
  logic sda_low;
  wire logic sda_line;
  msr_status_t status_in;
  logic [8:0] pin_speed;
  logic low_power_request;
  logic [8:0] speed_command_value;
  logic host_speed_takeover;
  logic low_power_inhibit;
  logic low_power_allow;
  logic config_write_enable;
  msr_wr_t cfg_wr;
  logic nonvolatile_reload;
  logic nonvolatile_program;
  logic ack_bit;
  logic [7:0] cfg_a;
  logic [7:0] cfg_d;
  logic [8:0] frz_speed;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  int m_lo = 0, m_msb = 0, m_val = 0, m_take = 0, m_key = 0, m_nvc = 0, m_stk = 0;
  int e_prog = 0, e_rel = 0, e_cfg = 0, n_prog = 0, n_rel = 0, n_cfg = 0;
  int c_addr = 0, c_data = 0;

  assign sda_line = ~(sda_low | (sda_oe & ~sda_o));

  msr_regs uut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .status_in(status_in), .pin_speed(pin_speed),
    .low_power_request(low_power_request), .speed_command_value(speed_command_value),
    .host_speed_takeover(host_speed_takeover), .low_power_inhibit(low_power_inhibit),
    .low_power_allow(low_power_allow), .config_write_enable(config_write_enable),
    .cfg_wr(cfg_wr), .nonvolatile_reload(nonvolatile_reload),
    .nonvolatile_program(nonvolatile_program));

  msr_host_model host (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // ======================================================
  // event counting and hang limit
  always @(posedge ref_clk) begin
    cycles++;
    if (nonvolatile_program === 1'b1) n_prog++;
    if (nonvolatile_reload === 1'b1) n_rel++;
    if (cfg_wr.stb === 1'b1) begin
      n_cfg++;
      cfg_a = cfg_wr.addr;
      cfg_d = cfg_wr.data;
    end
    if (cycles == 60000) begin
      fails++;
      print_verdict();
    end
  end

  // ======================================================
  // compares
  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t read 0x%h expected 0x%h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [8:0] got, input logic [8:0] exp, input string nm);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s is 0x%h expected 0x%h", $time, nm, got, exp);
    end
  endtask
  task automatic chk_ev(input int got, input int exp, input string nm);
    check_count++;
    if (got != exp) begin
      fails++;
      $display("[ERR] %0t %s count %0d expected %0d", $time, nm, got, exp);
    end
  endtask
  task automatic chk_state();
    repeat (2) @(posedge ref_clk);
    #1;
    chk_pin(speed_command_value, 9'((m_take != 0) ? m_val : int'(pin_speed)), "speed");
    chk_pin({8'h00, host_speed_takeover}, 9'(m_take), "takeover");
    chk_pin({8'h00, low_power_inhibit}, {8'h00, m_nvc[7]}, "inhibit");
    chk_pin({8'h00, low_power_allow}, {8'h00, low_power_request & ~m_nvc[7]}, "allow");
    chk_pin({8'h00, config_write_enable}, {8'h00, m_nvc[6]}, "cfg enable");
    chk_ev(n_prog, e_prog, "program");
    chk_ev(n_rel, e_rel, "reload");
    chk_ev(n_cfg, e_cfg, "cfg strobe");
    if (e_cfg > 0) begin
      chk_pin({1'b0, cfg_a}, 9'(c_addr), "cfg addr");
      chk_pin({1'b0, cfg_d}, 9'(c_data), "cfg data");
    end
    @(posedge ref_clk);
  endtask

  // ======================================================
  // register access with reference model update
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    host.reg_wr(a, d, ok);
    chk_pin({8'h00, ok}, 9'h001, "write ack");
    if (a == 8'h03 && d[4] && m_key == 'hb6) e_prog++;
    if (a == 8'h03 && d[5]) e_rel++;
    if (a >= 8'h20 && a <= 8'h2b && m_nvc[6]) begin
      e_cfg++;
      c_addr = a;
      c_data = d;
    end
    m_key = (a == 8'h02) ? d : 0;
    if (a == 8'h00) begin
      m_lo = d;
      m_val = {m_msb[0], d};
    end
    if (a == 8'h01) begin
      m_msb = d[0];
      m_take = d[7];
    end
    if (a == 8'h03) m_nvc = d & 8'hf0;
    chk_state();
  endtask
  task automatic rd(input logic [7:0] a);
    logic ok;
    logic [7:0] d;
    int e;
    case (a)
      8'h00: e = m_lo;
      8'h01: e = m_take * 128 + m_msb;
      8'h02: e = m_key;
      8'h03: e = m_nvc;
      8'h10: e = {status_in.thermal, status_in.low_power, m_stk[0], status_in.rotor, 4'h0};
      default: e = 0;
    endcase
    host.reg_rd(a, d, ok);
    chk_pin({8'h00, ok}, 9'h001, "read ack");
    chk_rd(d, 8'(e));
    if (a == 8'h10) m_stk = 0;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ======================================================
  // tests
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    status_in = '0;
    pin_speed = 9'h000;
    low_power_request = 1'b0;
    void'($urandom(32'h257d));
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    pin_speed <= 9'($urandom);
    chk_state();
    for (int k = 0; k < 3; k++) begin
      wr(8'h01, 8'hff);
      wr(8'h00, 8'($urandom));
      wr(8'h01, 8'h80);
      wr(8'h00, 8'($urandom));
    end
    rd(8'h00);
    wr(8'h01, 8'h7f);
    rd(8'h01);
    $display("test speed done");
    wr(8'h02, 8'hb6);
    wr(8'h03, 8'h10);
    wr(8'h02, 8'hb6);
    wr(8'h00, 8'h11);
    wr(8'h03, 8'h10);
    wr(8'h02, 8'hb7);
    rd(8'h02);
    wr(8'h03, 8'h10);
    rd(8'h02);
    $display("test key done");
    low_power_request <= 1'b1;
    wr(8'h03, 8'hef);
    rd(8'h03);
    for (int k = 0; k < 3; k++) wr(8'(8'h20 + $urandom_range(11)), 8'($urandom));
    wr(8'h03, 8'h40);
    wr(8'h03, 8'h00);
    wr(8'h2b, 8'h5a);
    rd(8'h20);
    $display("test control done");
    for (int k = 0; k < 4; k++) begin
      status_in <= msr_status_t'(4'($urandom) | 4'h2);
      repeat (3) @(posedge ref_clk);
      status_in.current <= 1'b0;
      m_stk = 1;
      @(posedge ref_clk);
      rd(8'h10);
      rd(8'h10);
      wr(8'h10, 8'hff);
      rd(8'h10);
    end
    $display("test status done");
    frz_speed = 9'((m_take != 0) ? m_val : int'(pin_speed));
    ce <= 1'b0;
    pin_speed <= ~pin_speed;
    status_in.current <= 1'b1;
    repeat (3) @(posedge ref_clk);
    status_in.current <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk_pin(speed_command_value, frz_speed, "frozen speed");
    @(posedge ref_clk);
    ce <= 1'b1;
    chk_state();
    rd(8'h10);
    $display("test freeze done");
    host.half = 20;
    wr(8'h01, 8'h81);
    wr(8'h00, 8'($urandom));
    host.dev_addr = 7'h53;
    host.reg_wr(8'h00, 8'h00, ack_bit);
    chk_pin({8'h00, ack_bit}, 9'h000, "foreign address ack");
    host.dev_addr = 7'h52;
    rd(8'h00);
    $display("test bus done");
    print_verdict();
  end
endmodule
`default_nettype wire
